// ==== rtl/rml_top.sv ====
// module: reset release, boot mode latch and external irq pin logic
`timescale 1ns/1ps

module rml_top #(
    parameter int unsigned PINS = rml_pkg::PIN_COUNT
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // boot select / irq pins, active low
    input wire logic [PINS-1:0] i_boot_sel_irq_n,
    // irq configuration from the core
    input wire logic [PINS-1:0] i_irq_edge,
    input wire logic [PINS-1:0] i_irq_mask,
    input wire logic [PINS-1:0] i_irq_ack,
    // low power states of the core
    input wire logic i_wait,
    input wire logic i_stop,
    // outputs
    output logic [PINS-1:0] o_operating_mode_reg,
    output logic [PINS-1:0] o_irq_req,
    output logic o_wait_exit,
    output logic o_stop_exit,
    output logic o_run,
    output logic [rml_pkg::PHASE_W-1:0] o_phase
);

    // elaboration check: the mode code is four pins wide
    if (PINS != rml_pkg::MODE_W) begin : g_bad_pins
        $error("PINS must equal the boot mode width");
    end

    // ********************************************************
    // synchronised pins
    // ********************************************************
    logic [PINS-1:0] pins_n; // synchronised, active low
    logic [PINS-1:0] pins_d_n; // previous synchronised value
    logic [PINS-1:0] fall; // falling edge seen this cycle
    logic [PINS-1:0] asserted; // pin level low

    // raw pins never reach logic before two flops
    rml_sync #(
        .WIDTH(PINS)
    ) u_sync (
        .i_clk(i_clk),
        .i_pins_n(i_boot_sel_irq_n),
        .o_pins_n(pins_n)
    );

    assign asserted = ~pins_n;
    assign fall = pins_d_n & ~pins_n;

    // edge history, idle high; a pin held low through reset reads as a fall until the first edge after release
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pins_d_n <= rml_pkg::PIN_IDLE;
        end else begin
            pins_d_n <= pins_n;
        end
    end

    // ********************************************************
    // start-up sequencer
    // ********************************************************
    rml_pkg::rml_state_t state_r; // sequencer state
    rml_pkg::rml_state_t state_nxt; // next state
    logic [rml_pkg::STARTUP_W-1:0] cnt_r; // start-up counter
    logic irq_live; // pins act as interrupts

    // fixed sequence from release so lock-step parts stay aligned
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            rml_pkg::RML_ST_RESET: begin
                state_nxt = rml_pkg::RML_ST_LATCH;
            end
            rml_pkg::RML_ST_LATCH: begin
                state_nxt = rml_pkg::RML_ST_START;
            end
            rml_pkg::RML_ST_START: begin
                if (cnt_r == rml_pkg::STARTUP_W'(
                        rml_pkg::STARTUP_CYCLES - 1)) begin
                    state_nxt = rml_pkg::RML_ST_RUN;
                end
            end
            rml_pkg::RML_ST_RUN: begin
                state_nxt = rml_pkg::RML_ST_RUN;
            end
            default: begin
                state_nxt = rml_pkg::RML_ST_RESET;
            end
        endcase
    end

    // state register; reset overrides everything
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_r <= rml_pkg::RML_ST_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // start-up counter counts only in the start state
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_r <= '0;
        end else if (state_r == rml_pkg::RML_ST_START) begin
            cnt_r <= cnt_r + 1'b1;
        end else begin
            cnt_r <= '0;
        end
    end

    // run flag: registered so the output comes from a flop
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_run <= 1'b0;
        end else begin
            o_run <= (state_nxt == rml_pkg::RML_ST_RUN);
        end
    end

    // interrupts only after the mode code is latched
    assign irq_live = (state_r == rml_pkg::RML_ST_START) ||
                      (state_r == rml_pkg::RML_ST_RUN);

    // ********************************************************
    // phase generator
    // ********************************************************
    // free running phase; reset brings it back to phase zero
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_phase <= rml_pkg::PHASE_RST;
        end else begin
            o_phase <= o_phase + 1'b1;
        end
    end

    // ********************************************************
    // boot mode latch
    // ********************************************************
    // captured from synchronised pins in the first cycle after
    // release; the pins must therefore be stable two cycles earlier
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_operating_mode_reg <= rml_pkg::MODE_RST;
        end else if (state_r == rml_pkg::RML_ST_RESET) begin
            o_operating_mode_reg <= pins_n;
        end
    end

    // ********************************************************
    // interrupt requests, one per pin
    // ********************************************************
    for (genvar g = 0; g < PINS; g++) begin : g_irq
        // edge mode holds a sticky flag; a new edge beats the ack
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                o_irq_req[g] <= 1'b0;
            end else if (!irq_live) begin
                o_irq_req[g] <= 1'b0;
            end else if (!i_irq_mask[g]) begin
                o_irq_req[g] <= 1'b0;
            end else if (i_irq_edge[g]) begin
                if (fall[g]) begin
                    o_irq_req[g] <= 1'b1;
                end else if (i_irq_ack[g]) begin
                    o_irq_req[g] <= 1'b0;
                end
            end else begin
                o_irq_req[g] <= asserted[g];
            end
        end
    end

    // ********************************************************
    // wait and stop exit
    // ********************************************************
    // exit one fixed cycle after a synchronised request, so parts
    // fed the same synchronous pin leave wait on the same edge
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_wait_exit <= 1'b0;
        end else begin
            o_wait_exit <= i_wait && irq_live &&
                           |(asserted & i_irq_mask);
        end
    end

    // stop wake uses the synchronised level of pin zero, mask not needed
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_stop_exit <= 1'b0;
        end else begin
            o_stop_exit <= i_stop && irq_live &&
                           asserted[rml_pkg::STOP_PIN];
        end
    end

    // ********************************************************
    // checks
    // ********************************************************
    sequence release_s;
        $fell(i_rst);
    endsequence

    sequence startup_s;
        !o_run [*6] ##1 o_run;
    endsequence

    startup_fixed_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        release_s |-> startup_s)
        else $error("start-up length not fixed");

    mode_latched_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (state_r == rml_pkg::RML_ST_RESET) |=>
        o_operating_mode_reg == $past(pins_n))
        else $error("mode not latched at release");

    mode_stable_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (state_r != rml_pkg::RML_ST_RESET) |=>
        $stable(o_operating_mode_reg))
        else $error("mode changed after latch");

    reset_hold_a: assert property (
        @(posedge i_clk)
        i_rst |=> (!o_run && o_irq_req == '0 && !o_wait_exit))
        else $error("logic active during reset");

    phase_reset_a: assert property (
        @(posedge i_clk)
        i_rst |=> o_phase == rml_pkg::PHASE_RST)
        else $error("phase not reset");

    irq_quiet_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !irq_live |=> o_irq_req == '0)
        else $error("irq before mode latched");

    level_irq_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (irq_live && i_irq_mask[0] && !i_irq_edge[0]) |=>
        o_irq_req[0] == $past(asserted[0]))
        else $error("level irq does not follow pin");

    edge_irq_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (irq_live && i_irq_mask[2] && i_irq_edge[2] && fall[2]) |=>
        o_irq_req[2])
        else $error("edge irq lost");

    wait_exit_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (i_wait && irq_live && |(asserted & i_irq_mask)) |=>
        o_wait_exit)
        else $error("wait exit not on fixed edge");

    stop_exit_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (i_stop && irq_live && asserted[rml_pkg::STOP_PIN]) |=>
        o_stop_exit)
        else $error("stop not left on pin zero");

    sync_delay_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        pins_n == $past(i_boot_sel_irq_n, 2))
        else $error("pin not seen after two flops");

endmodule

// ==== rtl/rml_pkg.sv ====
// package: constants and types for the reset, boot mode and interrupt pin block
package rml_pkg;

    // ********************************************************
    // pin and mode layout
    // ********************************************************
    localparam int unsigned PIN_COUNT = 4; // four boot select / irq pins
    localparam int unsigned MODE_W = 4; // boot mode code width
    localparam int unsigned SYNC_STAGES = 2; // synchroniser depth
    localparam int unsigned PHASE_W = 2; // phase generator width

    // ********************************************************
    // reset values
    // ********************************************************
    localparam logic [3:0] MODE_RST = 4'h0; // mode register before latch
    localparam logic [3:0] PIN_IDLE = 4'hF; // pins idle high (active low)
    localparam logic [1:0] PHASE_RST = 2'h0; // initial clock phase
    localparam logic [3:0] CFG_RST = 4'h0; // level sensitive after reset
    localparam logic [3:0] MASK_RST = 4'h0; // all requests masked

    // ********************************************************
    // start-up sequence timing
    // ********************************************************
    localparam int unsigned STARTUP_CYCLES = 4; // cycles spent in the start state
    localparam int unsigned STARTUP_W = 3; // width of start-up counter
    localparam int unsigned STOP_PIN = 0; // pin that wakes from stop

    // ********************************************************
    // start-up state machine
    // ********************************************************
    typedef enum logic [1:0] {
        RML_ST_RESET = 2'b00, // held in reset
        RML_ST_LATCH = 2'b01, // boot code captured
        RML_ST_START = 2'b10, // fixed start-up count
        RML_ST_RUN = 2'b11 // normal processing
    } rml_state_t;

endpackage

// ==== rtl/rml_sync.sv ====
// module: two flop synchroniser for the active low boot / irq pins
`timescale 1ns/1ps

module rml_sync #(
    parameter int unsigned WIDTH = 4
) (
    // clock
    input wire logic i_clk,
    // raw pins
    input wire logic [WIDTH-1:0] i_pins_n,
    // synchronised pins
    output logic [WIDTH-1:0] o_pins_n
);

    // ********************************************************
    // synchroniser chain
    // ********************************************************
    logic [WIDTH-1:0] meta_r; // first stage, read by stage two only

    // free running through reset: the boot code is read from this
    // chain on the first edge after release, so it must already hold
    // the true pin levels; a reset here would latch all ones instead
    always_ff @(posedge i_clk) begin
        meta_r <= i_pins_n;
        o_pins_n <= meta_r;
    end

endmodule

// ==== verification/rml_board.sv ====
// partner model: board reset source and interrupt pin drivers
`timescale 1ns/1ps

module rml_board (
    // board oscillator
    input wire logic i_clk,
    // requests from the bench
    input wire logic i_hold,
    input wire logic [3:0] i_pins_n,
    // board side pins
    output logic o_rst,
    output logic [3:0] o_pins_n
);
    // power rail flag: high until the bench takes reset over
    logic pwr_up_r = 1'b1;

    // the rail settles only once reset is held by the bench itself
    always @(negedge i_clk) begin
        if (i_hold) begin
            pwr_up_r <= 1'b0;
        end
    end

    // reset stands from time zero through power-up
    // released on a falling edge only, in step with the clock
    assign o_rst = i_hold | pwr_up_r;
    // pin levels move on falling edges only, synchronous sources
    assign o_pins_n = i_pins_n;
endmodule

// ==== verification/rml_top_test.sv ====
// testbench: boot mode latch, irq pins and wake logic of rml_top
`timescale 1ns/1ps

module rml_top_test;
    // ********************************************************
    // stimulus and observed signals
    // ********************************************************
    logic i_clk;
    logic hold;
    logic rst;
    logic [3:0] pins_n, pin_bus_n;
    logic [3:0] irq_edge, irq_mask, irq_ack;
    logic wait_st, stop_st;
    logic [3:0] mode, req;
    logic wexit, sexit, run;
    logic [1:0] phase;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    // row: pins, mask, {wait, stop}, expected req, wait exit, stop exit
    typedef struct packed {
        logic [3:0] pn;
        logic [3:0] mk;
        logic [1:0] ws;
        logic [3:0] rq;
        logic we;
        logic se;
    } rml_row_t;
    rml_row_t rows [8] = '{
        '{4'hF, 4'hF, 2'h3, 4'h0, 1'b0, 1'b0},
        '{4'hE, 4'hF, 2'h3, 4'h1, 1'b1, 1'b1},
        '{4'hE, 4'h0, 2'h3, 4'h0, 1'b0, 1'b1}, // stop ignores the mask
        '{4'h0, 4'h5, 2'h3, 4'h5, 1'b1, 1'b1},
        '{4'h7, 4'h8, 2'h3, 4'h8, 1'b1, 1'b0},
        '{4'h7, 4'h7, 2'h3, 4'h0, 1'b0, 1'b0},
        '{4'hB, 4'h4, 2'h3, 4'h4, 1'b1, 1'b0},
        '{4'h0, 4'hF, 2'h0, 4'hF, 1'b0, 1'b0}  // no wake when not asleep
    };

    rml_board rml_board_inst (
        .i_clk(i_clk),
        .i_hold(hold),
        .i_pins_n(pins_n),
        .o_rst(rst),
        .o_pins_n(pin_bus_n)
    );

    rml_top rml_top_inst (
        .i_clk(i_clk),
        .i_rst(rst),
        .i_boot_sel_irq_n(pin_bus_n),
        .i_irq_edge(irq_edge),
        .i_irq_mask(irq_mask),
        .i_irq_ack(irq_ack),
        .i_wait(wait_st),
        .i_stop(stop_st),
        .o_operating_mode_reg(mode),
        .o_irq_req(req),
        .o_wait_exit(wexit),
        .o_stop_exit(sexit),
        .o_run(run),
        .o_phase(phase)
    );

    // ********************************************************
    // clock, timeout and helpers
    // ********************************************************
    // stable clock from time zero, also while reset is held
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // a hang costs a mismatch; the run needs well under 1000 cycles
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            end_sim();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // inputs only move on falling edges, away from the sampling edge
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    // reset with all pins live as irqs, then release and follow start-up
    task automatic boot(input logic [3:0] code);
        hold = 1'b1;
        pins_n = code;
        irq_edge = 4'h0;
        irq_mask = 4'hF;
        wait_st = 1'b1;
        stop_st = 1'b1;
        tick(3);
        check({mode, req}, 8'h00);
        check({3'h0, wexit, sexit, run, phase}, 8'h00);
        hold = 1'b0;
        tick(1);
        check({mode, 2'h0, phase}, {code, 4'h1});
        check({4'h0, req}, 8'h00);
        pins_n = ~code;
        tick(4);
        check({7'h0, run}, 8'h00);
        tick(1);
        check({3'h0, run, mode}, {4'h1, code});
    endtask

    task automatic end_sim();
        $display("checks=%0d errors=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ********************************************************
    // main sequence
    // ********************************************************
    initial begin
        hold = 1'b1;
        pins_n = 4'hF;
        irq_edge = 4'h0;
        irq_mask = 4'h0;
        irq_ack = 4'h0;
        wait_st = 1'b0;
        stop_st = 1'b0;
        // every one of the sixteen boot codes, each after the first a mid-run reset
        for (int c = 0; c < 16; c++) begin
            boot(4'(c));
        end
        // level mode table, settled values
        foreach (rows[i]) begin
            pins_n = rows[i].pn;
            irq_mask = rows[i].mk;
            {wait_st, stop_st} = rows[i].ws;
            tick(4);
            check({4'h0, req}, {4'h0, rows[i].rq});
            check({7'h0, wexit}, {7'h0, rows[i].we});
            check({7'h0, sexit}, {7'h0, rows[i].se});
        end
        // exact latency through the synchroniser, request and wait exit
        pins_n = 4'hF;
        wait_st = 1'b1;
        tick(4);
        pins_n = 4'h7;
        tick(2);
        check({3'h0, wexit, req}, 8'h00);
        tick(1);
        check({3'h0, wexit, req}, 8'h18);
        // edge mode: request holds after the pin returns, ack clears it
        pins_n = 4'hF;
        irq_edge = 4'h4;
        irq_mask = 4'h4;
        tick(4);
        check({4'h0, req}, 8'h00);
        pins_n = 4'hB;
        tick(3);
        check({4'h0, req}, 8'h04);
        pins_n = 4'hF;
        tick(4);
        check({4'h0, req}, 8'h04);
        irq_ack = 4'h4;
        tick(1);
        irq_ack = 4'h0;
        tick(1);
        check({4'h0, req}, 8'h00);
        end_sim();
    end
endmodule
